// File: shared/adic_pkg.sv
// Function
// - Start launches a positioning move to the stored point that point select names.
// - Start is honoured only outside manual mode; otherwise it is ignored.
// - Seven point select inputs form a binary number, input n weighs two to n.
// - In manual mode an inch input moves that way until released or soft limit.
// - The manual input selects manual mode; inching and teaching work only there.
// - Teach stores the actual position into the point that point select names.
// - Count mode zero plus the continuous count override behaves as count mode one.
// - With full count override, a push move at torque disregards the push limit value.
// - In position is high while commanded and actual position agree within tolerance.
// - Alarm is high exactly while a controller fault is present.
// - Ready is high only while idle and able to accept commands.
// - Moving is high for the whole of any motor movement.
// - Home complete is low during a home return and high once it finished.
// - Servo excited follows the energized servo, forced low by stop or error.
// - Point echo shows the selected point with the same binary weighting.
// - During motion torque cap hit is high when current reaches the limit.
// - While a fault exists the four fault code outputs carry its binary code.
// - During motion, zone hit is high when position lies within lower to upper.
// - Approach window lights approach_window the new target of a point move, solid in position.
// - Travel limit exceeded is high while the position is beyond a soft limit.
package adic_pkg;

    localparam int POS_W       = 32;
    localparam int CUR_W       = 16;
    localparam int PARAM_W     = 16;
    localparam int POINT_W     = 7;
    localparam int FAULT_W     = 4;
    localparam int POINT_COUNT = 1 << POINT_W;

    // Parameter addresses, and the count mode values that the override logic uses.
    localparam logic [PARAM_W-1:0] COUNT_MODE_ADDR   = 16'h0503;
    localparam logic [PARAM_W-1:0] APPROACH_TOL_ADDR = 16'h011D;
    localparam logic [PARAM_W-1:0] COUNT_MODE_ZERO   = 16'h0000;
    localparam logic [PARAM_W-1:0] COUNT_MODE_ONE    = 16'h0001;

    localparam logic [FAULT_W-1:0] FAULT_NONE = 4'h0;
    localparam logic [POINT_W-1:0] POINT_ZERO = 7'h00;
    localparam logic [POS_W-1:0]   POS_ZERO   = 32'h00000000;

    // Teach hold time and its cycle count at the 100 MHz clock.
    localparam int CLOCK_HZ          = 100_000_000;
    localparam int TEACH_HOLD_MS     = 20;
    localparam int TEACH_HOLD_CYCLES = TEACH_HOLD_MS * (CLOCK_HZ / 1000);

    typedef enum logic [1:0] {
        ADIC_ST_INIT = 2'b00,
        ADIC_ST_IDLE = 2'b01,
        ADIC_ST_MOVE = 2'b10,
        ADIC_ST_JOG  = 2'b11
    } adic_state_e;

    typedef enum logic [1:0] {
        ADIC_MV_ABS  = 2'b00,
        ADIC_MV_INC  = 2'b01,
        ADIC_MV_PUSH = 2'b10
    } adic_move_e;

    // Settings held by the parameter store of the controller.
    typedef struct packed {
        logic [POS_W-1:0]   target_tolerance;
        logic [POS_W-1:0]   approach_tolerance;
        logic [POS_W-1:0]   zone_lower;
        logic [POS_W-1:0]   zone_upper;
        logic [POS_W-1:0]   soft_limit_fwd;
        logic [POS_W-1:0]   soft_limit_rev;
        logic [CUR_W-1:0]   torque_limit;
        logic [PARAM_W-1:0] count_mode;
        adic_move_e         point_kind;
    } adic_cfg_s;

    // State reported by the motion core on the same clock.
    typedef struct packed {
        logic [POS_W-1:0]   actual_position;
        logic [CUR_W-1:0]   motor_current;
        logic               motion_busy;
        logic               home_busy;
        logic               home_done;
        logic               servo_energized;
        logic               emergency_stop;
        logic               fault_present;
        logic [FAULT_W-1:0] fault_code;
        logic               push_reached;
        logic               init_done;
    } adic_core_s;

    // Discrete input pins, asynchronous to the clock.
    typedef struct packed {
        logic               start;
        logic               manual;
        logic               inch_forward;
        logic               inch_reverse;
        logic               teach;
        logic               continuous_count_override;
        logic               full_count_override;
        logic [POINT_W-1:0] point_select;
    } adic_pins_s;

    localparam int PINS_W = $bits(adic_pins_s);

endpackage

// File: rtl/adic_control.sv
`timescale 1ns/1ps
module adic_control #(
    parameter int TEACH_HOLD = adic_pkg::TEACH_HOLD_CYCLES
) (
    // Clock and reset.
    input  wire logic                          CLOCK,
    input  wire logic                          RST,
    // Discrete input pins.
    input  wire adic_pkg::adic_pins_s          PINS,
    // Settings and motion core state.
    input  wire adic_pkg::adic_cfg_s           CFG,
    input  wire adic_pkg::adic_core_s          CORE,
    // Commands to the motion core.
    output logic                               MOVE_GO,
    output logic [adic_pkg::POS_W-1:0]         MOVE_TARGET,
    output logic                               INCH_FWD_RUN,
    output logic                               INCH_REV_RUN,
    output logic [adic_pkg::PARAM_W-1:0]       COUNT_MODE_EFFECTIVE,
    output logic                               PUSH_LIMIT_IGNORE,
    // Discrete status outputs.
    output logic                               IN_POSITION,
    output logic                               ALARM,
    output logic                               READY,
    output logic                               MOVING,
    output logic                               HOME_COMPLETE,
    output logic                               SERVO_EXCITED,
    output logic [adic_pkg::POINT_W-1:0]       POINT_ECHO,
    output logic                               TORQUE_CAP_HIT,
    output logic [adic_pkg::FAULT_W-1:0]       FAULT_CODE,
    output logic                               ZONE_HIT,
    output logic                               APPROACH_WINDOW,
    output logic                               TRAVEL_LIMIT_EXCEEDED
);

    // True when two signed positions differ by no more than the tolerance.
    function automatic logic within_tol(input logic [adic_pkg::POS_W-1:0] a,
                                        input logic [adic_pkg::POS_W-1:0] b,
                                        input logic [adic_pkg::POS_W-1:0] tol);
        logic [adic_pkg::POS_W:0] d;
        begin
            d = {a[adic_pkg::POS_W-1], a} - {b[adic_pkg::POS_W-1], b};
            if (d[adic_pkg::POS_W]) begin
                d = -d;
            end
            within_tol = (d <= {1'b0, tol});
        end
    endfunction

    // Two flip-flop synchroniser per pin; only the second stage is read.
    logic [adic_pkg::PINS_W-1:0] sync_a;
    logic [adic_pkg::PINS_W-1:0] sync_b;
    genvar gi;
    generate
        for (gi = 0; gi < adic_pkg::PINS_W; gi++) begin : g_sync
            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= PINS[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    adic_pkg::adic_pins_s pin;
    adic_pkg::adic_pins_s pin_q;
    assign pin = adic_pkg::adic_pins_s'(sync_b);

    // Previous pin levels for edge detection.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pin_q <= '0;
        end else begin
            pin_q <= pin;
        end
    end

    // Point memory and control state.
    logic [adic_pkg::POS_W-1:0]   point_mem [adic_pkg::POINT_COUNT];
    adic_pkg::adic_state_e        state;
    adic_pkg::adic_state_e        next_state;
    logic [adic_pkg::POS_W-1:0]   cmd_pos;
    logic [adic_pkg::POS_W-1:0]   next_cmd_pos;
    logic [adic_pkg::POINT_W-1:0] point;
    logic [adic_pkg::POINT_W-1:0] next_point;
    logic [31:0]                  teach_cnt;
    logic                         teach_done;
    logic                         approach_armed;
    logic                         moving_seen;

    // Edge and mode decode.
    wire start_rise  = pin.start & ~pin_q.start;
    wire teach_rise  = pin.teach & ~pin_q.teach;
    wire manual_mode = pin.manual;
    wire fault       = CORE.fault_present;
    wire servo_ok    = CORE.servo_energized & ~CORE.emergency_stop & ~fault;
    wire busy        = CORE.motion_busy | CORE.home_busy;
    wire idle_ok     = (state == adic_pkg::ADIC_ST_IDLE) & ~busy & ~fault & servo_ok;
    wire start_ok    = start_rise & ~manual_mode & idle_ok;
    wire [adic_pkg::POS_W-1:0] pos = CORE.actual_position;

    // Soft limit decode, signed compares.
    wire beyond_fwd = $signed(pos) > $signed(CFG.soft_limit_fwd);
    wire beyond_rev = $signed(pos) < $signed(CFG.soft_limit_rev);
    wire at_fwd     = $signed(pos) >= $signed(CFG.soft_limit_fwd);
    wire at_rev     = $signed(pos) <= $signed(CFG.soft_limit_rev);
    wire jog_fwd    = manual_mode & pin.inch_forward & ~pin.inch_reverse & ~at_fwd;
    wire jog_rev    = manual_mode & pin.inch_reverse & ~pin.inch_forward & ~at_rev;
    wire jog_any    = (jog_fwd | jog_rev) & servo_ok & ~fault;
    wire in_zone    = ($signed(pos) >= $signed(CFG.zone_lower)) & ($signed(pos) <= $signed(CFG.zone_upper));
    wire at_target  = within_tol(cmd_pos, pos, CFG.target_tolerance);
    wire approach_window_tgt   = within_tol(cmd_pos, pos, CFG.approach_tolerance);
    wire teach_hold = manual_mode & pin.teach & ~teach_done;
    wire teach_fire = teach_hold & (teach_cnt == 32'(TEACH_HOLD - 1));
    wire point_move = (CFG.point_kind == adic_pkg::ADIC_MV_ABS) | (CFG.point_kind == adic_pkg::ADIC_MV_INC);
    wire cmode_zero = CFG.count_mode == adic_pkg::COUNT_MODE_ZERO;

    // Next state and command selection.
    always_comb begin
        next_state   = state;
        next_cmd_pos = cmd_pos;
        next_point   = point;
        case (state)
            adic_pkg::ADIC_ST_INIT: begin
                if (CORE.init_done) begin
                    next_state = adic_pkg::ADIC_ST_IDLE;
                end
            end
            adic_pkg::ADIC_ST_IDLE: begin
                if (start_ok) begin
                    next_state   = adic_pkg::ADIC_ST_MOVE;
                    next_point   = pin.point_select;
                    next_cmd_pos = point_mem[pin.point_select];
                end else if (jog_any & ~busy) begin
                    next_state = adic_pkg::ADIC_ST_JOG;
                end else if (manual_mode & teach_rise) begin
                    next_point = pin.point_select;
                end
            end
            adic_pkg::ADIC_ST_MOVE: begin
                if ((moving_seen & ~CORE.motion_busy) | fault) begin
                    next_state = adic_pkg::ADIC_ST_IDLE;
                end
            end
            adic_pkg::ADIC_ST_JOG: begin
                next_cmd_pos = pos;
                if (~jog_any) begin
                    next_state = adic_pkg::ADIC_ST_IDLE;
                end
            end
            default: begin
                next_state = adic_pkg::ADIC_ST_INIT;
            end
        endcase
    end

    // Control registers.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state   <= adic_pkg::ADIC_ST_INIT;
            cmd_pos <= adic_pkg::POS_ZERO;
            point   <= adic_pkg::POINT_ZERO;
        end else begin
            state   <= next_state;
            cmd_pos <= next_cmd_pos;
            point   <= next_point;
        end
    end

    // The core may take a cycle to raise busy, so the move ends only after busy was seen, or on a fault.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            moving_seen <= 1'b0;
        end else begin
            moving_seen <= (state == adic_pkg::ADIC_ST_MOVE) & (moving_seen | CORE.motion_busy);
        end
    end

    // Teach stores once per press after the hold time, so a bouncing contact cannot store twice.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            teach_cnt  <= 32'h00000000;
            teach_done <= 1'b0;
        end else if (~(manual_mode & pin.teach) | teach_rise) begin
            teach_cnt  <= 32'h00000000;
            teach_done <= 1'b0;
        end else if (teach_hold) begin
            teach_cnt  <= teach_cnt + 32'h00000001;
            teach_done <= teach_fire;
        end
    end

    // Point store has no reset; stored points survive a reset as they would in retained memory.
    always_ff @(posedge CLOCK) begin
        if (teach_fire) begin
            point_mem[point] <= pos;
        end
    end

    // Approach arming follows each new point move target.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            approach_armed <= 1'b0;
        end else if (start_ok) begin
            approach_armed <= point_move;
        end else if (state == adic_pkg::ADIC_ST_JOG) begin
            approach_armed <= 1'b0;
        end
    end

    // Home complete: cleared while homing, set when it finishes.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            HOME_COMPLETE <= 1'b0;
        end else if (CORE.home_busy) begin
            HOME_COMPLETE <= 1'b0;
        end else if (CORE.home_done) begin
            HOME_COMPLETE <= 1'b1;
        end
    end

    // Registered command outputs.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            MOVE_GO              <= 1'b0;
            MOVE_TARGET          <= adic_pkg::POS_ZERO;
            INCH_FWD_RUN         <= 1'b0;
            INCH_REV_RUN         <= 1'b0;
            COUNT_MODE_EFFECTIVE <= adic_pkg::COUNT_MODE_ZERO;
            PUSH_LIMIT_IGNORE    <= 1'b0;
        end else begin
            MOVE_GO              <= start_ok;
            MOVE_TARGET          <= start_ok ? point_mem[pin.point_select] : MOVE_TARGET;
            INCH_FWD_RUN         <= jog_fwd & jog_any & (next_state == adic_pkg::ADIC_ST_JOG);
            INCH_REV_RUN         <= jog_rev & jog_any & (next_state == adic_pkg::ADIC_ST_JOG);
            COUNT_MODE_EFFECTIVE <= (cmode_zero & pin.continuous_count_override) ?
                                    adic_pkg::COUNT_MODE_ONE : CFG.count_mode;
            PUSH_LIMIT_IGNORE    <= pin.full_count_override & CORE.push_reached &
                                    (CFG.point_kind == adic_pkg::ADIC_MV_PUSH);
        end
    end

    // Registered status outputs.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            IN_POSITION           <= 1'b0;
            ALARM                 <= 1'b0;
            READY                 <= 1'b0;
            MOVING                <= 1'b0;
            SERVO_EXCITED         <= 1'b0;
            POINT_ECHO            <= adic_pkg::POINT_ZERO;
            TORQUE_CAP_HIT        <= 1'b0;
            FAULT_CODE            <= adic_pkg::FAULT_NONE;
            ZONE_HIT              <= 1'b0;
            APPROACH_WINDOW       <= 1'b0;
            TRAVEL_LIMIT_EXCEEDED <= 1'b0;
        end else begin
            IN_POSITION           <= at_target & (state != adic_pkg::ADIC_ST_INIT);
            ALARM                 <= fault;
            READY                 <= idle_ok & ~start_ok;
            MOVING                <= busy | INCH_FWD_RUN | INCH_REV_RUN;
            SERVO_EXCITED         <= servo_ok;
            POINT_ECHO            <= point;
            TORQUE_CAP_HIT        <= busy & (CORE.motor_current >= CFG.torque_limit);
            FAULT_CODE            <= fault ? CORE.fault_code : adic_pkg::FAULT_NONE;
            ZONE_HIT              <= busy & in_zone;
            APPROACH_WINDOW       <= approach_armed & approach_window_tgt;
            TRAVEL_LIMIT_EXCEEDED <= beyond_fwd | beyond_rev;
        end
    end

    // Checks on the decoded behaviour.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    chk_start_launch: assert property (start_ok |=> MOVE_GO && MOVE_TARGET == $past(point_mem[pin.point_select]))
        else $error("Start did not launch the selected point.");
    chk_manual_blocks: assert property (manual_mode |=> !MOVE_GO)
        else $error("Start acted during manual mode.");
    chk_jog_limit: assert property (INCH_FWD_RUN |-> $past(manual_mode) && !$past(at_fwd))
        else $error("Forward inch ran outside manual or at the limit.");
    chk_teach_store: assert property (teach_fire |=> point_mem[$past(point)] == $past(pos))
        else $error("Teach did not store the actual position.");
    chk_count_override: assert property (cmode_zero && pin.continuous_count_override
                                         |=> COUNT_MODE_EFFECTIVE == adic_pkg::COUNT_MODE_ONE)
        else $error("Count mode override not applied.");
    chk_alarm_follow: assert property (fault |=> ALARM && FAULT_CODE == $past(CORE.fault_code))
        else $error("Alarm or fault code missing during a fault.");
    chk_ready_idle: assert property (READY |-> $past(state) == adic_pkg::ADIC_ST_IDLE && !$past(busy))
        else $error("Ready shown while not idle.");
    chk_home_clear: assert property (CORE.home_busy |=> !HOME_COMPLETE)
        else $error("Home complete high during home return.");
    chk_servo_error: assert property (fault || CORE.emergency_stop |=> !SERVO_EXCITED)
        else $error("Servo excited stayed high on error or stop.");
    chk_soft_limit: assert property (beyond_fwd |=> TRAVEL_LIMIT_EXCEEDED)
        else $error("Soft limit flag missing.");
    chk_init_ready: assert property (state == adic_pkg::ADIC_ST_INIT |=> !READY)
        else $error("Ready before initialisation finished.");

    cov_point_move: cover property (start_ok ##1 MOVE_GO ##[1:100] MOVING);
    cov_jog_run: cover property (manual_mode && pin.inch_forward ##[1:4] INCH_FWD_RUN);
    cov_teach: cover property (teach_fire);
    cov_approach_window: cover property (APPROACH_WINDOW && IN_POSITION);

endmodule // adic_control

// File: testbench/adic_core_model.sv
`timescale 1ns/1ps
module adic_core_model #(
    parameter int MOVE_CYCLES = 6
) (
    // Clock and reset.
    input  wire logic                          CLOCK,
    input  wire logic                          RST,
    // Commands from the control block.
    input  wire logic                          MOVE_GO,
    input  wire logic [adic_pkg::POS_W-1:0]    MOVE_TARGET,
    input  wire logic                          INCH_FWD_RUN,
    input  wire logic                          INCH_REV_RUN,
    // Fault code injected by the bench, zero for none.
    input  wire logic [adic_pkg::FAULT_W-1:0]  FAULT_IN,
    // Reported motion state.
    output adic_pkg::adic_core_s               CORE
);
    int busy_left;
    int home_left;

    // A move keeps the axis busy for a few cycles and only then lands on the target, so a
    // control block that drops its moving flag early is caught. Jogging steps one count a cycle.
    // A short home return runs after reset, and a landed move counts as a push that reached torque.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            CORE <= '0;
            busy_left <= 0;
            home_left <= 4;
        end else begin
            CORE.init_done <= 1'b1;
            CORE.servo_energized <= 1'b1;
            CORE.fault_present <= |FAULT_IN;
            CORE.fault_code <= FAULT_IN;
            CORE.motion_busy <= (busy_left != 0) | MOVE_GO | INCH_FWD_RUN | INCH_REV_RUN;
            CORE.motor_current <= ((busy_left != 0) | MOVE_GO) ? 16'h0040 : 16'h0000;
            CORE.home_busy <= home_left > 1;
            CORE.home_done <= home_left == 1;
            if (home_left != 0) begin
                home_left <= home_left - 1;
            end
            if (MOVE_GO) begin
                busy_left <= MOVE_CYCLES;
            end else if (busy_left != 0) begin
                busy_left <= busy_left - 1;
            end
            if (busy_left == 1) begin
                CORE.actual_position <= MOVE_TARGET;
                CORE.push_reached <= 1'b1;
            end else if (INCH_FWD_RUN) begin
                CORE.actual_position <= CORE.actual_position + 32'h00000001;
            end else if (INCH_REV_RUN) begin
                CORE.actual_position <= CORE.actual_position - 32'h00000001;
            end
        end
    end
endmodule // adic_core_model

// File: testbench/test_axis_discrete_io_control.sv
`timescale 1ns/1ps
module test_axis_discrete_io_control;
    localparam int HOLD = 8;
    logic                 CLOCK = 1'b0;
    logic                 RST   = 1'b1;
    adic_pkg::adic_pins_s pins  = '0;
    adic_pkg::adic_cfg_s  cfg   = '0;
    adic_pkg::adic_core_s core;
    logic [3:0]           fault = 4'h0;
    logic                 go, fwd, rev, pli, inp, alarm, ready, moving, home, servo, trq, zone, appr, lim;
    logic [6:0]           echo;
    logic [3:0]           code;
    logic [31:0]          target, taught;
    logic [15:0]          cme;
    int                   miscompares = 0;
    int                   check_count = 0;
    int                   go_seen = 0;

    always #5 CLOCK = ~CLOCK;

    // Launch pulses are counted so that refused starts can be told from accepted ones.
    always @(negedge CLOCK) if (go === 1'b1) go_seen++;

    adic_control #(.TEACH_HOLD(HOLD)) uut (.CLOCK(CLOCK), .RST(RST), .PINS(pins), .CFG(cfg),
        .CORE(core), .MOVE_GO(go), .MOVE_TARGET(target), .INCH_FWD_RUN(fwd), .INCH_REV_RUN(rev),
        .COUNT_MODE_EFFECTIVE(cme), .PUSH_LIMIT_IGNORE(pli), .IN_POSITION(inp), .ALARM(alarm),
        .READY(ready), .MOVING(moving), .HOME_COMPLETE(home), .SERVO_EXCITED(servo),
        .POINT_ECHO(echo), .TORQUE_CAP_HIT(trq), .FAULT_CODE(code), .ZONE_HIT(zone),
        .APPROACH_WINDOW(appr), .TRAVEL_LIMIT_EXCEEDED(lim));

    adic_core_model partner (.CLOCK(CLOCK), .RST(RST), .MOVE_GO(go), .MOVE_TARGET(target),
        .INCH_FWD_RUN(fwd), .INCH_REV_RUN(rev), .FAULT_IN(fault), .CORE(core));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge CLOCK);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Bounded wait for ready; running out of patience ends the run.
    task automatic wait_ready();
        for (int i = 0; i < 200 && ready !== 1'b1; i++) @(negedge CLOCK);
        if (ready !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: ready never rose", $time);
            results();
        end
    endtask

    // Main sequence; every pin changes on the falling edge.
    initial begin
        cfg.soft_limit_fwd = 32'h00001000;
        cfg.zone_upper = 32'h00000100;
        cfg.torque_limit = 16'h0040;
        cfg.count_mode = 16'h0003;
        cfg.point_kind = adic_pkg::ADIC_MV_ABS;
        cycles(5);
        check(moving, 0);
        check(home, 0);
        check(ready, 0);
        RST = 1'b0;
        wait_ready();
        check(home, 1);
        pins.manual = 1'b1;
        pins.inch_forward = 1'b1;
        cycles(10);
        check(fwd, 1);
        check(moving, 1);
        check(zone, 1);
        check(trq, 0);
        pins.inch_forward = 1'b0;
        cycles(8);
        check(moving, 0);
        pins.point_select = 7'h29;
        pins.teach = 1'b1;
        cycles(HOLD + 6);
        taught = core.actual_position;
        pins.teach = 1'b0;
        cycles(4);
        check(echo, 7'h29);
        pins.inch_reverse = 1'b1;
        cycles(6);
        check(rev, 1);
        pins.inch_reverse = 1'b0;
        cycles(8);
        check(rev, 0);
        pins.start = 1'b1;
        cycles(6);
        check(go_seen, 0);
        pins.start = 1'b0;
        pins.manual = 1'b0;
        cycles(4);
        wait_ready();
        pins.start = 1'b1;
        cycles(6);
        check(go_seen, 1);
        check(target, taught);
        check(moving, 1);
        check(trq, 1);
        check(zone, 1);
        pins.start = 1'b0;
        cycles(12);
        check(moving, 0);
        check(trq, 0);
        check(zone, 0);
        check(inp, 1);
        check(appr, 1);
        check(ready, 1);
        pins.continuous_count_override = 1'b1;
        cfg.count_mode = 16'h0000;
        cycles(4);
        check(cme, 16'h0001);
        cfg.count_mode = 16'h0002;
        cycles(2);
        check(cme, 16'h0002);
        // The landed move stands in for a push that reached its torque.
        cfg.point_kind = adic_pkg::ADIC_MV_PUSH;
        pins.full_count_override = 1'b1;
        cycles(4);
        check(pli, 1);
        pins.full_count_override = 1'b0;
        cycles(4);
        check(pli, 0);
        cfg.point_kind = adic_pkg::ADIC_MV_ABS;
        // The axis rests at the taught position, so a limit below it must be flagged.
        cfg.soft_limit_fwd = 32'h00000008;
        cycles(3);
        check(lim, 1);
        cfg.soft_limit_fwd = 32'h00001000;
        cycles(3);
        check(lim, 0);
        // Every fault code in turn must reach the outputs and drop the servo flag.
        for (int c = 1; c < 16; c++) begin
            fault = c[3:0];
            cycles(3);
            check(alarm, 1);
            check(code, c);
            check(servo, 0);
        end
        fault = 4'h0;
        cycles(3);
        check(alarm, 0);
        check(servo, 1);
        results();
    end
endmodule // test_axis_discrete_io_control
